// >>> design/gpfs_consts.svh
`ifndef GPFS_CONSTS_SVH
`define GPFS_CONSTS_SVH
// How it works
// - Forty two-way pins in five ports of eight, pin index 0 to 7.
// - After reset all function selects are zero, so every pin but port 0 pin 6 is plain GPIO.
// - Port data register read always returns live pin levels, whatever the function.
// - Logic-array inputs always follow their pins, whatever function is selected.
// - In power-saving mode pin drive and pad parameters hold their state; registers stay writable.
// - Two-bit selector per pin at bits 4n+1:4n; other bit pairs reserved.
// - Code 00 is GPIO; 01, 10, 11 pick first, second, third alternate function.
// - Port 0 pin 7 code 01 drives core clock unless clock source field is 11.
// - Convert-start input on port 2 pin 0 works under every selector code.
// - Pad parameters for ports 0, 1: pull-up disable, two-bit drive, reserved bit.
// - Pull-up switchable only on port 0 pins 0,4-7 and all port 1 pins.
// - Port 0 pin 6 leaves reset as reset output until firmware reassigns it.

// Register byte addresses
`define GPFS_ADDR_FS0      32'hfffff400
`define GPFS_ADDR_FS1      32'hfffff404
`define GPFS_ADDR_FS2      32'hfffff408
`define GPFS_ADDR_FS3      32'hfffff40c
`define GPFS_ADDR_FS4      32'hfffff410
`define GPFS_ADDR_PAR0     32'hfffff42c
`define GPFS_ADDR_PAR1     32'hfffff43c
`define GPFS_ADDR_DAT0     32'hfffff450
`define GPFS_ADDR_DAT1     32'hfffff454
`define GPFS_ADDR_DAT2     32'hfffff458
`define GPFS_ADDR_DAT3     32'hfffff45c
`define GPFS_ADDR_DAT4     32'hfffff460

// Reset values
`define GPFS_FS_RST        32'h00000000
`define GPFS_PAR0_RST      32'h20000000
`define GPFS_PAR1_RST      32'h00000000
`define GPFS_DAT_RST       16'h0000
`define GPFS_PINS_OE_RST   40'h0000000040
`define GPFS_PAD_DRV_RST   32'h00004000

// Writable bit masks
`define GPFS_FS_WMASK      32'h33333333
`define GPFS_PAR_WMASK     32'h77777777

// Port data register fields
`define GPFS_DAT_IN_LSB    0
`define GPFS_DAT_OUT_LSB   8
`define GPFS_DAT_OE_LSB    16

// Pad parameter field offsets within a 4-bit pin slice
`define GPFS_PAR_PUD_BIT   0
`define GPFS_PAR_DRV_LSB   1

// Alternate function exists masks, bit = port*8+pin
`define GPFS_ALT1_EXISTS   40'h00fff6ffff
`define GPFS_ALT2_EXISTS   40'hffffffffbf
`define GPFS_ALT3_EXISTS   40'hffff07fff9

// Switchable pull-up masks
`define GPFS_PU_SW_P0      8'hf1
`define GPFS_PU_SW_P1      8'hff

// Special pins
`define GPFS_PIN_CLK       7
`define GPFS_PIN_RSTOUT    6
`define GPFS_PIN_CONV      16
`define GPFS_CLKSRC_EXT    2'h3
`define GPFS_CODE_GPIO     2'h0
`define GPFS_CODE_ALT1     2'h1
`endif

// >>> design/gpfs_pkg.sv
package gpfs_pkg;
  // Pin-side drive towards the pads
  typedef struct packed {
    logic [39:0] out;
    logic [39:0] oe;
  } gpfs_pins_t;

  // Pad parameters applied to the pads
  typedef struct packed {
    logic [39:0] pull_up_en;
    logic [31:0] drive;
  } gpfs_pad_t;

  // Alternate function drive from peripherals, one slice per code 01..11
  typedef struct packed {
    logic [2:0][39:0] out;
    logic [2:0][39:0] oe;
  } gpfs_alt_t;
endpackage : gpfs_pkg

// >>> design/gpfs_top.sv
`timescale 1ns/1ns
`include "gpfs_consts.svh"

module gpfs_top #(
  parameter int NUM_PORTS = 5
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [31:0]         addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  input  wire logic [39:0]         pin_in,
  output gpfs_pkg::gpfs_pins_t     pins,
  output gpfs_pkg::gpfs_pad_t      pad,
  input  wire gpfs_pkg::gpfs_alt_t alt,
  output logic [2:0][39:0]         alt_in,
  output logic [15:0]              logic_array_input,
  output logic                     convert_start_input_n,
  output logic                     core_clock_output_en,
  output logic                     external_clock_input_en,
  input  wire logic [1:0]          clock_source_field,
  input  wire logic                power_save
);

  // Elaboration check: the pin map is fixed at five ports of eight
  if (NUM_PORTS != 5) begin : g_bad_ports
    $error("gpfs_top serves exactly five ports");
  end

  typedef struct packed {
    logic [4:0][31:0]    fs;
    logic [1:0][31:0]    par;
    logic [1:0][31:0]    par_applied;
    logic [4:0][15:0]    dat;
    logic [39:0]         sync1;
    logic [39:0]         sync2;
    gpfs_pkg::gpfs_pins_t pins;
    gpfs_pkg::gpfs_pad_t pad;
    logic [2:0][39:0]    alt_in;
    logic [15:0]         pla;
    logic                conv_n;
    logic                core_clock_output;
    logic                external_clock_input;
    logic                rstout;
    logic [31:0]         rdata;
  } gpfs_state_t;

  gpfs_state_t st_reg;
  gpfs_state_t st_next;

  // Selector of one pin out of the select registers
  function automatic logic [1:0] sel_of(input logic [4:0][31:0] fs, input int pin);
    logic [31:0] w;
    w = fs[pin / 8];
    return w[(pin % 8) * 4 +: 2];
  endfunction : sel_of

  // Whether the alternate function for a code exists on a pin
  function automatic logic alt_exists(input logic [1:0] code, input int pin);
    logic [39:0] m1;
    logic [39:0] m2;
    logic [39:0] m3;
    m1 = `GPFS_ALT1_EXISTS;
    m2 = `GPFS_ALT2_EXISTS;
    m3 = `GPFS_ALT3_EXISTS;
    case (code)
      2'h1:    alt_exists = m1[pin];
      2'h2:    alt_exists = m2[pin];
      2'h3:    alt_exists = m3[pin];
      default: alt_exists = 1'b1;
    endcase
  endfunction : alt_exists

  // Pad parameters from an applied register pair, fixed pull-up elsewhere
  function automatic gpfs_pkg::gpfs_pad_t pad_of(input logic [1:0][31:0] par);
    gpfs_pkg::gpfs_pad_t p;
    logic [7:0]          m0;
    logic [7:0]          m1;
    m0 = `GPFS_PU_SW_P0;
    m1 = `GPFS_PU_SW_P1;
    p.pull_up_en = {40{1'b1}};
    p.drive      = '0;
    for (int k = 0; k < 8; k++) begin
      p.drive[k * 2 +: 2]       = par[0][k * 4 + `GPFS_PAR_DRV_LSB +: 2];
      p.drive[16 + k * 2 +: 2]  = par[1][k * 4 + `GPFS_PAR_DRV_LSB +: 2];
      if (m0[k]) begin
        p.pull_up_en[k] = ~par[0][k * 4 + `GPFS_PAR_PUD_BIT];
      end
      if (m1[k]) begin
        p.pull_up_en[8 + k] = ~par[1][k * 4 + `GPFS_PAR_PUD_BIT];
      end
    end
    return p;
  endfunction : pad_of

  // Port data word: zero top byte, output enables, output values, live levels
  function automatic logic [31:0] dat_word(input logic [15:0] d, input logic [7:0] lvl8);
    return {8'h00, d, lvl8};
  endfunction : dat_word

  // Next-state logic
  always_comb begin
    logic [1:0]  code;
    logic [39:0] lvl;
    logic [39:0] gout;
    logic [39:0] goe;
    code    = '0;
    lvl     = st_reg.sync2;
    gout    = '0;
    goe     = '0;
    st_next = st_reg;

    // Two-flop synchroniser on pad inputs
    st_next.sync1 = pin_in;
    st_next.sync2 = st_reg.sync1;

    // Register writes, reserved bits dropped
    if (wr) begin
      case (addr)
        `GPFS_ADDR_FS0: begin
          st_next.fs[0]  = wdata & `GPFS_FS_WMASK;
          st_next.rstout = 1'b0;
        end
        `GPFS_ADDR_FS1:  st_next.fs[1]  = wdata & `GPFS_FS_WMASK;
        `GPFS_ADDR_FS2:  st_next.fs[2]  = wdata & `GPFS_FS_WMASK;
        `GPFS_ADDR_FS3:  st_next.fs[3]  = wdata & `GPFS_FS_WMASK;
        `GPFS_ADDR_FS4:  st_next.fs[4]  = wdata & `GPFS_FS_WMASK;
        `GPFS_ADDR_PAR0: st_next.par[0] = wdata & `GPFS_PAR_WMASK;
        `GPFS_ADDR_PAR1: st_next.par[1] = wdata & `GPFS_PAR_WMASK;
        `GPFS_ADDR_DAT0: begin
          st_next.dat[0]         = wdata[`GPFS_DAT_OUT_LSB +: 16];
          st_next.par_applied[0] = st_reg.par[0];
        end
        `GPFS_ADDR_DAT1: begin
          st_next.dat[1]         = wdata[`GPFS_DAT_OUT_LSB +: 16];
          st_next.par_applied[1] = st_reg.par[1];
        end
        `GPFS_ADDR_DAT2: st_next.dat[2] = wdata[`GPFS_DAT_OUT_LSB +: 16];
        `GPFS_ADDR_DAT3: st_next.dat[3] = wdata[`GPFS_DAT_OUT_LSB +: 16];
        `GPFS_ADDR_DAT4: st_next.dat[4] = wdata[`GPFS_DAT_OUT_LSB +: 16];
        default: st_next.rdata = st_reg.rdata;
      endcase
    end

    // Read data, valid in the cycle after the strobe only
    st_next.rdata = '0;
    if (rd) begin
      case (addr)
        `GPFS_ADDR_FS0:  st_next.rdata = st_reg.fs[0];
        `GPFS_ADDR_FS1:  st_next.rdata = st_reg.fs[1];
        `GPFS_ADDR_FS2:  st_next.rdata = st_reg.fs[2];
        `GPFS_ADDR_FS3:  st_next.rdata = st_reg.fs[3];
        `GPFS_ADDR_FS4:  st_next.rdata = st_reg.fs[4];
        `GPFS_ADDR_PAR0: st_next.rdata = st_reg.par[0];
        `GPFS_ADDR_PAR1: st_next.rdata = st_reg.par[1];
        `GPFS_ADDR_DAT0: st_next.rdata = dat_word(st_reg.dat[0], lvl[7:0]);
        `GPFS_ADDR_DAT1: st_next.rdata = dat_word(st_reg.dat[1], lvl[15:8]);
        `GPFS_ADDR_DAT2: st_next.rdata = dat_word(st_reg.dat[2], lvl[23:16]);
        `GPFS_ADDR_DAT3: st_next.rdata = dat_word(st_reg.dat[3], lvl[31:24]);
        `GPFS_ADDR_DAT4: st_next.rdata = dat_word(st_reg.dat[4], lvl[39:32]);
        default:         st_next.rdata = '0;
      endcase
    end

    // Per-pin function mux over forty pins
    for (int p = 0; p < 40; p++) begin
      code = sel_of(st_reg.fs, p);
      case (code)
        `GPFS_CODE_GPIO: begin
          gout[p] = st_reg.dat[p / 8][p % 8];
          goe[p]  = st_reg.dat[p / 8][8 + p % 8];
        end
        default: begin
          if (alt_exists(code, p)) begin
            gout[p] = alt.out[code - 2'h1][p];
            goe[p]  = alt.oe[code - 2'h1][p];
          end
        end
      endcase
      for (int c = 1; c < 4; c++) begin
        st_next.alt_in[c - 1][p] = (code == 2'(c) && alt_exists(code, p)) ? lvl[p] : 1'b1;
      end
    end

    // Port 0 pin 7 clock in or clock out
    st_next.core_clock_output = 1'b0;
    st_next.external_clock_input = 1'b0;
    if (sel_of(st_reg.fs, `GPFS_PIN_CLK) == `GPFS_CODE_ALT1) begin
      if (clock_source_field == `GPFS_CLKSRC_EXT) begin
        st_next.external_clock_input           = 1'b1;
        goe[`GPFS_PIN_CLK]     = 1'b0;
      end else begin
        st_next.core_clock_output = 1'b1;
      end
    end

    // Reset output held on port 0 pin 6 until firmware rewrites port 0 select
    if (st_reg.rstout) begin
      gout[`GPFS_PIN_RSTOUT] = 1'b1;
      goe[`GPFS_PIN_RSTOUT]  = 1'b1;
    end

    // Pins and pads freeze in power-saving mode
    if (!power_save) begin
      st_next.pins.out = gout;
      st_next.pins.oe  = goe;
      st_next.pad      = pad_of(st_reg.par_applied);
    end

    // Logic-array inputs and convert start ignore the selectors
    st_next.pla    = {lvl[31:24], lvl[0], lvl[14:8]};
    st_next.conv_n = lvl[`GPFS_PIN_CONV];
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg.fs          <= {5{`GPFS_FS_RST}};
      st_reg.par         <= {`GPFS_PAR1_RST, `GPFS_PAR0_RST};
      st_reg.par_applied <= {`GPFS_PAR1_RST, `GPFS_PAR0_RST};
      st_reg.dat         <= {5{`GPFS_DAT_RST}};
      st_reg.sync1       <= '1;
      st_reg.sync2       <= '1;
      st_reg.pins.out    <= '0;
      st_reg.pins.oe     <= `GPFS_PINS_OE_RST;
      st_reg.pad         <= {{40{1'b1}}, `GPFS_PAD_DRV_RST};
      st_reg.alt_in      <= '1;
      st_reg.pla         <= '1;
      st_reg.conv_n      <= 1'b1;
      st_reg.core_clock_output        <= 1'b0;
      st_reg.external_clock_input        <= 1'b0;
      st_reg.rstout      <= 1'b1;
      st_reg.rdata       <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign rdata                   = st_reg.rdata;
  assign pins                    = st_reg.pins;
  assign pad                     = st_reg.pad;
  assign alt_in                  = st_reg.alt_in;
  assign logic_array_input       = st_reg.pla;
  assign convert_start_input_n   = st_reg.conv_n;
  assign core_clock_output_en    = st_reg.core_clock_output;
  assign external_clock_input_en = st_reg.external_clock_input;

endmodule : gpfs_top

// >>> bench/gpfs_props.sv
`timescale 1ns/1ns
module gpfs_props #(
  parameter int NUM_PORTS = 5
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire logic [31:0]          addr,
  input wire logic                 rd,
  input wire logic [31:0]          rdata,
  input wire logic [39:0]          pin_in,
  input wire gpfs_pkg::gpfs_pins_t pins,
  input wire gpfs_pkg::gpfs_pad_t  pad,
  input wire logic [15:0]          logic_array_input,
  input wire logic                 convert_start_input_n,
  input wire logic                 core_clock_output_en,
  input wire logic                 external_clock_input_en,
  input wire logic [1:0]           clock_source_field,
  input wire logic                 power_save
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Reset image, then the reset output drives high
  sequence s_rst_img;
    pins.oe == 40'h40 && pins.out == 40'h0 && pad.pull_up_en == 40'hffffffffff && pad.drive == 32'h4000;
  endsequence
  sequence s_rst_out;
    pins.out[6] && pins.oe[6];
  endsequence
  // Enough running edges for a pin level to pass the synchroniser
  sequence s_live;
    ce [*4];
  endsequence
  property p_reset_state;
    $fell(rst) |-> s_rst_img ##1 s_rst_out;
  endproperty
  property p_fs_rsvd;
    ce && rd && addr inside {[32'hfffff400:32'hfffff410]} |=> (rdata & 32'hcccccccc) == 32'h0;
  endproperty
  property p_par_rsvd;
    ce && rd && (addr == 32'hfffff42c || addr == 32'hfffff43c) |=> (rdata & 32'h88888888) == 32'h0;
  endproperty
  property p_unmapped;
    ce && rd && addr == 32'hfffff414 |=> rdata == 32'h0;
  endproperty
  property p_conv_live;
    s_live |-> convert_start_input_n == $past(pin_in[16], 3);
  endproperty
  property p_pla_live;
    s_live |-> logic_array_input == {$past(pin_in[31:24], 3), $past(pin_in[0], 3), $past(pin_in[14:8], 3)};
  endproperty
  property p_power_hold;
    ce && power_save |=> $stable(pins) && $stable(pad);
  endproperty
  property p_ext_clk;
    !power_save ##1 external_clock_input_en |-> !pins.oe[7] && !core_clock_output_en;
  endproperty
  property p_core_clk;
    (clock_source_field == 2'h3) [*3] |-> !core_clock_output_en;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("pin state after reset wrong");
  a_fs_rsvd: assert property (p_fs_rsvd) else $error("select reserved bits not zero");
  a_par_rsvd: assert property (p_par_rsvd) else $error("pad reserved bits not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_conv_live: assert property (p_conv_live) else $error("convert start not following pin");
  a_pla_live: assert property (p_pla_live) else $error("logic array input not following pins");
  a_power_hold: assert property (p_power_hold) else $error("pins changed in power save");
  a_ext_clk: assert property (p_ext_clk) else $error("clock pin driven while input");
  a_core_clk: assert property (p_core_clk) else $error("core clock out with external source");
endmodule : gpfs_props

bind gpfs_top gpfs_props #(.NUM_PORTS(NUM_PORTS)) gpfs_props_i (
  .clk, .rst, .ce, .addr, .rd, .rdata, .pin_in, .pins, .pad, .logic_array_input, .convert_start_input_n,
  .core_clock_output_en, .external_clock_input_en, .clock_source_field, .power_save);

// >>> bench/gpfs_pads.sv
`timescale 1ns/1ns
module gpfs_pads (
  input  wire logic                 clk,
  input  wire gpfs_pkg::gpfs_pins_t pins,
  input  wire gpfs_pkg::gpfs_pad_t  pad,
  input  wire logic [39:0]          ext_en,
  input  wire logic [39:0]          ext_val,
  output logic [39:0]               pin_in
);
  logic [39:0] float_reg = 40'h0;
  // An undriven pin without pull-up wanders every cycle
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  // Pad drive wins, then outside drive, then pull-up or floating level
  assign pin_in = (pins.oe & pins.out) | (~pins.oe & ext_en & ext_val) | (~pins.oe & ~ext_en & (pad.pull_up_en | float_reg));
endmodule : gpfs_pads

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb;
  logic                 clk, rst, ce, wr, rd, conv_n, cco_en, eci_en, power_save;
  logic [31:0]          addr, wdata, rdata;
  logic [39:0]          pin_in, ext_en, ext_val;
  logic [15:0]          lai;
  logic [1:0]           csf;
  logic [2:0][39:0]     alt_in;
  gpfs_pkg::gpfs_pins_t pins;
  gpfs_pkg::gpfs_pad_t  pad;
  gpfs_pkg::gpfs_alt_t  alt;
  int                   mismatches, check_count;

  gpfs_top gpfs_top_i (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pins, .pad, .alt, .alt_in,
    .logic_array_input(lai), .convert_start_input_n(conv_n), .core_clock_output_en(cco_en),
    .external_clock_input_en(eci_en), .clock_source_field(csf), .power_save);
  gpfs_pads gpfs_pads_i (.clk, .pins, .pad, .ext_en, .ext_val, .pin_in);

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string w, input logic [39:0] e, input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input string w, input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(w, e & m, rdata & m);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {addr, wdata, wr, rd, csf, power_save} = '0;
    ext_en = 40'h00ff01ff01;
    ext_val = 40'h00c3005a01;
    alt = {{40'h5a00000000, 40'h0, 40'h0}, {40'hff00000000, 40'hff3c000000, 40'h80}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk("rst_out", 2'h3, {pins.out[6], pins.oe[6]});
    for (int i = 0; i < 5; i++) rd_chk("fs_rst", 32'hfffff400 + 32'(4 * i), 32'h0, 32'hffffffff);
    rd_chk("par0_rst", 32'hfffff42c, 32'h20000000, 32'hffffffff);
    rd_chk("par1_rst", 32'hfffff43c, 32'h0, 32'hffffffff);
    reg_wr(32'hfffff414, 32'hffffffff);
    rd_chk("unmapped", 32'hfffff414, 32'h0, 32'hffffffff);
    reg_wr(32'hfffff404, 32'hffffffff);
    rd_chk("fs1_rsvd", 32'hfffff404, 32'h33333333, 32'hffffffff);
    reg_wr(32'hfffff43c, 32'hffffffff);
    rd_chk("par1_rsvd", 32'hfffff43c, 32'h77777777, 32'hffffffff);
    $display("test registers done");
    reg_wr(32'hfffff42c, 32'h00000017);
    settle(3);
    chk("drive_early", 2'h0, pad.drive[1:0]);
    reg_wr(32'hfffff450, 32'h0);
    reg_wr(32'hfffff454, 32'h0);
    settle(3);
    chk("pu_p0", 2'h2, pad.pull_up_en[1:0]);
    chk("pu_p1", 8'h0, pad.pull_up_en[15:8]);
    chk("drive_p0", 4'h3, pad.drive[3:0]);
    $display("test pads done");
    reg_wr(32'hfffff458, 32'h00ff5500);
    settle(4);
    chk("p2_drive", 16'hff55, {pins.oe[23:16], pins.out[23:16]});
    rd_chk("p2_level", 32'hfffff458, 32'h55, 32'hff);
    reg_wr(32'hfffff40c, 32'h22222222);
    settle(4);
    chk("p3_oe", 8'h3c, pins.oe[31:24]);
    chk("p3_bus_in", 8'hc3, alt_in[1][31:24]);
    chk("p3_unsel", 8'hff, alt_in[0][31:24]);
    chk("pla_in", 16'hc3da, lai);
    rd_chk("p3_level", 32'hfffff45c, 32'hc3, 32'hff);
    @(posedge clk);
    power_save <= 1'b1;
    reg_wr(32'hfffff40c, 32'h0);
    settle(3);
    chk("hold", 8'h3c, pins.oe[31:24]);
    @(posedge clk);
    power_save <= 1'b0;
    settle(3);
    chk("p3_gpio", 8'h0, pins.oe[31:24]);
    $display("test routing done");
    for (int c = 0; c < 4; c++) begin
      reg_wr(32'hfffff410, 32'h11111111 * c);
      settle(3);
      chk("p4_oe", (c > 1) ? 8'hff : 8'h0, pins.oe[39:32]);
      chk("p4_out", (c == 3) ? 8'h5a : 8'h0, pins.out[39:32]);
      if (c == 1) chk("p4_no_alt", 8'hff, alt_in[0][39:32]);
    end
    // A write with the clock enable low must leave the register alone
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(32'hfffff410, 32'h0);
    ce <= 1'b1;
    rd_chk("ce_hold", 32'hfffff410, 32'h33333333, 32'hffffffff);
    reg_wr(32'hfffff458, 32'h0);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      ext_val[16] <= c[0];
      reg_wr(32'hfffff408, 32'(c));
      settle(4);
      chk("conv", c[0], conv_n);
    end
    $display("test codes done");
    reg_wr(32'hfffff400, 32'h10000000);
    settle(3);
    chk("clk_out", 3'h5, {cco_en, eci_en, pins.oe[7]});
    chk("rst_out_off", 2'h0, {pins.out[6], pins.oe[6]});
    @(posedge clk);
    csf <= 2'h3;
    settle(3);
    chk("clk_in", 3'h2, {cco_en, eci_en, pins.oe[7]});
    $display("test clock pin done");
    report_and_stop();
  end
endmodule : tb
